/* core/udsc_core.sv */
`timescale 1ns/10ps
module udsc_core
    import udsc_pkg::*;
(
    input wire logic mclk, // 200 MHz system clock
    input wire logic srst, // hardware reset, synchronous, active high
    input wire logic por, // power-on reset, clears the persistent copy
    input wire logic [4:0] phy_addr, // strapped management address (pins)
    input wire logic mdc, // management clock pin
    input wire logic mdio_in, // management data pin level
    output logic mdio_out, // management data driven value
    output logic mdio_oe_n, // low while this block drives the data pin
    input wire logic cable_energy, // energy seen on the cable (analogue side)
    output logic energy_detect_out, // energy-detect pin
    output logic deep_sleep, // deepest standby power-down request
    output logic hi_thresh_en, // high threshold comparator enable
    output logic slow_osc_sel, // slow oscillator replaces the normal clock
    output logic nv_copy_en, // persistent copy enabled
    output logic rx_term_dis // receive termination disabled
);
    // pin synchronisers; first stages feed only second stages
    logic mdc_s1_r, mdc_s2_r, mdc_s3_r;
    logic mdio_s1_r, mdio_s2_r;
    logic nrg_s1_r, nrg_s2_r;
    logic [4:0] pad_s1_r, pad_s2_r;

    // management frame receiver
    udsc_mdio_e st_r; // receiver state
    logic [5:0] ones_r; // consecutive preamble ones, saturating
    logic [3:0] cnt_r; // bit counter inside a field
    logic [12:0] hdr_r; // start bit, opcode, address, register
    logic [15:0] sh_r; // data shift register
    logic wr_stb_r; // one-cycle write strobe to the register file
    logic [4:0] wr_reg_r; // register being written
    logic [15:0] wr_dat_r; // data being written

    // registers and persistent copy
    logic [15:0] ctrl2_r;
    udsc_ctrl3_s ctrl3_r;
    logic [15:0] nv2_r, nv3_r; // persistent copies, kept across srst
    logic nv_valid_r; // a copy was enabled before the reset

    // energy detection and standby
    logic det_r; // filtered energy present
    logic [DLY_W-1:0] dly_r; // energy-loss delay counter
    logic sleep_r; // latched deepest standby

    // decode of the received header
    wire logic mdc_rise = mdc_s2_r & ~mdc_s3_r;
    wire logic bit_in = mdio_s2_r;
    wire logic [1:0] hdr_op = hdr_r[11:10];
    wire logic addr_hit = (hdr_r[12] == 1'b1) && (hdr_r[9:5] == pad_s2_r);
    wire logic is_rd = addr_hit && (hdr_op == OP_RD);
    wire logic is_wr = addr_hit && (hdr_op == OP_WR);
    wire logic [15:0] ctrl3_bits = ctrl3_r;
    // unmapped registers read as zero
    wire logic [15:0] rd_data = (hdr_r[4:0] == REG_CTRL2) ? ctrl2_r :
                                (hdr_r[4:0] == REG_CTRL3) ? ctrl3_bits : 16'h0000;
    // restore values applied by a hardware reset
    wire logic [15:0] ctrl2_boot = nv_valid_r ? (nv2_r & CTRL2_NV_MASK) : CTRL2_RST;
    wire logic [15:0] ctrl3_boot = nv_valid_r ? (nv3_r & CTRL3_NV_MASK) : CTRL3_RST;
    // delay limit from loss of energy
    wire logic [DLY_W-1:0] dly_lim = ctrl3_r.long_delay ? DLY_W'(DLY_LONG_CYC - 1) :
                                     DLY_W'(DLY_MIN_CYC - 1);
    // entry condition for the deepest standby
    wire logic enter_sleep = ctrl3_r.sleep_en &&
                             (ctrl3_r.method_host ? ctrl3_r.manual_sleep : ~det_r);

    // two flip-flops on every pin input, a third on the clock pin for edge detection
    always_ff @(posedge mclk)
    begin
        mdc_s1_r <= mdc;
        mdc_s2_r <= mdc_s1_r;
        mdc_s3_r <= mdc_s2_r;
        mdio_s1_r <= mdio_in;
        mdio_s2_r <= mdio_s1_r;
        nrg_s1_r <= cable_energy;
        nrg_s2_r <= nrg_s1_r;
        pad_s1_r <= phy_addr;
        pad_s2_r <= pad_s1_r;
    end

    // management frame receiver, advanced on each synchronised clock rise;
    // the read bit changes just after a rise so the host sees it stable at the next
    always_ff @(posedge mclk)
    begin
        wr_stb_r <= 1'b0;
        if (srst)
        begin
            st_r <= ST_PRE;
            ones_r <= 6'h00;
            cnt_r <= 4'h0;
            hdr_r <= 13'h0000;
            sh_r <= 16'h0000;
            wr_reg_r <= 5'h00;
            wr_dat_r <= 16'h0000;
            mdio_out <= 1'b1;
            mdio_oe_n <= 1'b1;
        end
        else if (mdc_rise)
        begin
            case (st_r)
                ST_PRE:
                begin
                    // a zero after a full preamble is the first start bit
                    if (bit_in)
                        ones_r <= (ones_r == PRE_ONES) ? ones_r : ones_r + 6'h01;
                    else
                    begin
                        ones_r <= 6'h00;
                        if (ones_r == PRE_ONES)
                        begin
                            st_r <= ST_HDR;
                            cnt_r <= 4'h0;
                        end
                    end
                end
                ST_HDR:
                begin
                    hdr_r <= {hdr_r[11:0], bit_in};
                    cnt_r <= cnt_r + 4'h1;
                    if (cnt_r == HDR_LAST)
                    begin
                        st_r <= ST_TA;
                        cnt_r <= 4'h0;
                    end
                end
                ST_TA:
                begin
                    cnt_r <= cnt_r + 4'h1;
                    if (cnt_r == 4'h0)
                    begin
                        // second turnaround bit: drive zero on a read
                        if (is_rd)
                        begin
                            mdio_out <= 1'b0;
                            mdio_oe_n <= 1'b0;
                        end
                    end
                    else if (is_rd)
                    begin
                        mdio_out <= rd_data[15];
                        sh_r <= {rd_data[14:0], 1'b0};
                        st_r <= ST_RD;
                        cnt_r <= 4'h0;
                    end
                    else if (is_wr)
                    begin
                        st_r <= ST_WR;
                        cnt_r <= 4'h0;
                    end
                    else
                        // other address or opcode: ignore the frame
                        st_r <= ST_PRE;
                end
                ST_RD:
                begin
                    cnt_r <= cnt_r + 4'h1;
                    if (cnt_r == DATA_LAST)
                    begin
                        mdio_out <= 1'b1;
                        mdio_oe_n <= 1'b1;
                        st_r <= ST_PRE;
                    end
                    else
                    begin
                        mdio_out <= sh_r[15];
                        sh_r <= {sh_r[14:0], 1'b0};
                    end
                end
                ST_WR:
                begin
                    sh_r <= {sh_r[14:0], bit_in};
                    cnt_r <= cnt_r + 4'h1;
                    if (cnt_r == DATA_LAST)
                    begin
                        wr_stb_r <= 1'b1;
                        wr_reg_r <= hdr_r[4:0];
                        wr_dat_r <= {sh_r[14:0], bit_in};
                        st_r <= ST_PRE;
                    end
                end
                default:
                    st_r <= ST_PRE;
            endcase
        end
    end

    // register file; hardware reset reloads from the persistent copy if valid
    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            ctrl2_r <= ctrl2_boot;
            ctrl3_r <= ctrl3_boot;
        end
        else if (wr_stb_r && (wr_reg_r == REG_CTRL2))
            ctrl2_r <= wr_dat_r;
        else if (wr_stb_r && (wr_reg_r == REG_CTRL3))
            ctrl3_r <= wr_dat_r;
    end

    // persistent copy: only power-on clears it, so it survives the wake reset;
    // it tracks the live registers while the enable bit is set
    always_ff @(posedge mclk)
    begin
        if (por)
        begin
            nv2_r <= 16'h0000;
            nv3_r <= 16'h0000;
            nv_valid_r <= 1'b0;
        end
        else
        begin
            nv_valid_r <= ctrl3_r.nv_en;
            if (ctrl3_r.nv_en)
            begin
                nv2_r <= ctrl2_r & CTRL2_NV_MASK;
                nv3_r <= ctrl3_bits;
            end
        end
    end

    // energy filter: drops only after energy stays absent for the chosen delay;
    // starts as present so a restored automatic mode waits before sleeping
    always_ff @(posedge mclk)
    begin
        if (srst)
        begin
            det_r <= 1'b1;
            dly_r <= '0;
        end
        else if (nrg_s2_r)
        begin
            det_r <= 1'b1;
            dly_r <= '0;
        end
        else if (det_r)
        begin
            if (dly_r >= dly_lim)
                det_r <= 1'b0;
            else
                dly_r <= dly_r + DLY_W'(1);
        end
    end

    // standby latch: nothing but the hardware reset clears it
    always_ff @(posedge mclk)
    begin
        if (srst)
            sleep_r <= 1'b0;
        else if (enter_sleep)
            sleep_r <= 1'b1;
    end

    // registered outputs
    always_ff @(posedge mclk)
    begin
        if (srst)
            energy_detect_out <= 1'b1;
        else
            // forced true while the mode is off, then polarity applied
            energy_detect_out <= (ctrl3_r.sleep_en ? det_r : 1'b1)
                                 ^ ctrl3_r.det_active_low;
    end

    // control bits driven straight from the register flops
    assign hi_thresh_en = ctrl2_r[CTRL2_HI_THRESH_BIT];
    assign slow_osc_sel = ctrl2_r[CTRL2_SLOW_OSC_BIT];
    assign nv_copy_en = ctrl3_r.nv_en;
    assign rx_term_dis = ctrl3_r.rx_term_dis;
    assign deep_sleep = sleep_r;
endmodule

/* core/udsc_pkg.sv */
package udsc_pkg;
    // management register addresses
    localparam logic [4:0] REG_CTRL2 = 5'h13;
    localparam logic [4:0] REG_CTRL3 = 5'h14;
    // values after reset when no persistent copy is valid
    localparam logic [15:0] CTRL2_RST = 16'h0000;
    localparam logic [15:0] CTRL3_RST = 16'h0000;
    // bits kept in the persistent copy: ctrl2 [9:8] and [1:0]
    localparam logic [15:0] CTRL2_NV_MASK = 16'h0303;
    // whole ctrl3 is kept except the manual entry bit, so a wake reset cannot re-enter
    localparam logic [15:0] CTRL3_NV_MASK = 16'hFFDF;
    // field positions in ctrl2
    localparam int CTRL2_HI_THRESH_BIT = 15;
    localparam int CTRL2_SLOW_OSC_BIT = 0;
    // clock rate and energy-loss delays
    localparam int CLK_MHZ = 200;
    localparam int DLY_MIN_NS = 1000;
    localparam int DLY_LONG_NS = 20000;
    localparam int DLY_MIN_CYC = (DLY_MIN_NS * CLK_MHZ + 999) / 1000;
    localparam int DLY_LONG_CYC = (DLY_LONG_NS * CLK_MHZ + 999) / 1000;
    localparam int DLY_W = 12;
    // management frame shape
    localparam logic [5:0] PRE_ONES = 6'h20;
    localparam logic [3:0] HDR_LAST = 4'hC;
    localparam logic [3:0] DATA_LAST = 4'hF;
    localparam logic [1:0] OP_RD = 2'h2;
    localparam logic [1:0] OP_WR = 2'h1;

    // management frame receiver states
    typedef enum logic [2:0] {
        ST_PRE = 3'b000,
        ST_HDR = 3'b001,
        ST_TA = 3'b010,
        ST_WR = 3'b011,
        ST_RD = 3'b100
    } udsc_mdio_e;

    // layout of the third front-end control register
    typedef struct packed {
        logic [8:0] rsvd;
        logic method_host;
        logic manual_sleep;
        logic nv_en;
        logic sleep_en;
        logic rx_term_dis;
        logic long_delay;
        logic det_active_low;
    } udsc_ctrl3_s;
endpackage

/* test/udsc_host.sv */
`timescale 1ns/10ps
// management host: clock still between frames, pin changes at falling mclk
module udsc_host
    import udsc_pkg::*;
(
    input wire logic mclk, // system clock
    input wire logic line, // resolved data pin level
    output logic mdc, // management clock
    output logic drv, // value the host drives
    output logic drv_en // host drives the pin
);
    initial
    begin
        mdc = 1'b0;
        drv = 1'b1;
        drv_en = 1'b0;
    end
    // one whole frame; a read lets go of the pin from turnaround on
    task automatic xfer(input logic [1:0] op, input logic [4:0] pa, input logic [4:0] ra,
        input logic [15:0] wd, output logic [15:0] rd);
        logic [63:0] f;
        f = {32'hFFFFFFFF, 2'b01, op, pa, ra, 2'b10, wd};
        for (int i = 63; i >= 0; i--)
        begin
            @(negedge mclk);
            mdc = 1'b0;
            drv = f[i];
            drv_en = (op == OP_WR) || (i > 17);
            repeat (5) @(negedge mclk);
            // sample what the device set up after the previous rise
            if (i < 16)
                rd[i] = line;
            mdc = 1'b1;
            repeat (4) @(negedge mclk);
        end
        @(negedge mclk);
        mdc = 1'b0;
        drv_en = 1'b0;
        repeat (10) @(negedge mclk);
    endtask
endmodule

/* test/udsc_properties.sv */
`timescale 1ns/10ps
// watches the pins of the standby control block
module udsc_props
    import udsc_pkg::*;
(
    input wire logic mclk,
    input wire logic srst,
    input wire logic por,
    input wire logic [4:0] phy_addr,
    input wire logic mdc,
    input wire logic mdio_in,
    input wire logic mdio_out,
    input wire logic mdio_oe_n,
    input wire logic cable_energy,
    input wire logic energy_detect_out,
    input wire logic deep_sleep,
    input wire logic hi_thresh_en,
    input wire logic slow_osc_sel,
    input wire logic nv_copy_en,
    input wire logic rx_term_dis
);
    logic mdc_d_r; // last clock pin level
    logic [4:0] rise_cnt_r; // clock rises seen while the data pin is driven
    logic [3:0] since_rise_r; // cycles since the last clock rise, saturating
    wire logic mdc_rise = mdc & ~mdc_d_r;
    // a write can only land a few cycles after a clock rise, so count them
    always_ff @(posedge mclk)
    begin
        mdc_d_r <= mdc;
        rise_cnt_r <= (srst | mdio_oe_n) ? 5'h00 : rise_cnt_r + {4'h0, mdc_rise};
        since_rise_r <= (srst | mdc_rise) ? 4'h0 :
                        since_rise_r + {3'h0, since_rise_r != 4'hF};
    end
    sequence s_reset_two;
        srst ##1 srst;
    endsequence
    sequence s_por_two;
        (srst && por) ##1 (srst && por);
    endsequence
    a_sleep_held: assert property (@(posedge mclk) disable iff (srst) deep_sleep |=> deep_sleep)
        else $error("standby left without reset");
    a_reset_wakes: assert property (@(posedge mclk) srst |=> !deep_sleep && !hi_thresh_en)
        else $error("reset left standby or threshold set");
    a_bus_released: assert property (@(posedge mclk) srst |=> mdio_oe_n && mdio_out)
        else $error("data pin driven after reset");
    a_detect_forced: assert property (@(posedge mclk) s_reset_two |=> energy_detect_out)
        else $error("detect output not true after reset");
    a_copy_kept: assert property (@(posedge mclk) srst && !por && nv_copy_en |=> nv_copy_en)
        else $error("copy enable lost over reset");
    a_por_clears: assert property (@(posedge mclk)
        s_por_two |=> !nv_copy_en && !slow_osc_sel && !rx_term_dis)
        else $error("power-on reset kept old values");
    a_idle_high: assert property (@(posedge mclk) disable iff (srst) mdio_oe_n |-> mdio_out)
        else $error("idle data value not high");
    a_drive_window: assert property (@(posedge mclk) disable iff (srst) rise_cnt_r <= 5'h11)
        else $error("data pin driven too long");
    a_write_only: assert property (@(posedge mclk) disable iff (srst)
        !$past(srst) && $changed({hi_thresh_en, slow_osc_sel, nv_copy_en, rx_term_dis})
        |-> since_rise_r <= 4'h8)
        else $error("control output moved without a write");
endmodule
bind udsc_core udsc_props u_props (.mclk(mclk), .srst(srst), .por(por), .phy_addr(phy_addr),
    .mdc(mdc), .mdio_in(mdio_in), .mdio_out(mdio_out), .mdio_oe_n(mdio_oe_n),
    .cable_energy(cable_energy), .energy_detect_out(energy_detect_out),
    .deep_sleep(deep_sleep), .hi_thresh_en(hi_thresh_en), .slow_osc_sel(slow_osc_sel),
    .nv_copy_en(nv_copy_en), .rx_term_dis(rx_term_dis));

/* test/ultra_deep_sleep_control_tb.sv */
`timescale 1ns/10ps
// register-level bench for the deepest standby control block
module ultra_deep_sleep_control_tb
    import udsc_pkg::*;
;
    logic mclk = 1'b0, srst = 1'b1, por = 1'b1, cable_energy = 1'b1, mdio_in;
    logic [4:0] phy_addr = 5'h05; // strapped address
    logic mdc, mdio_out, mdio_oe_n, energy_detect_out, deep_sleep, h_drv, h_en;
    logic hi_thresh_en, slow_osc_sel, nv_copy_en, rx_term_dis;
    logic [15:0] rd;
    int miscompares = 0, tests_run = 0;
    always #2.5 mclk = ~mclk;
    // pull-up holds the pin high when nobody drives
    assign mdio_in = !mdio_oe_n ? mdio_out : (h_en ? h_drv : 1'b1);
    udsc_core DUT (.mclk(mclk), .srst(srst), .por(por), .phy_addr(phy_addr), .mdc(mdc),
        .mdio_in(mdio_in), .mdio_out(mdio_out), .mdio_oe_n(mdio_oe_n),
        .cable_energy(cable_energy), .energy_detect_out(energy_detect_out),
        .deep_sleep(deep_sleep), .hi_thresh_en(hi_thresh_en), .slow_osc_sel(slow_osc_sel),
        .nv_copy_en(nv_copy_en), .rx_term_dis(rx_term_dis));
    udsc_host h (.mclk(mclk), .line(mdio_in), .mdc(mdc), .drv(h_drv), .drv_en(h_en));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge mclk);
    endtask
    task automatic wr(input logic [4:0] ra, input logic [15:0] wd);
        h.xfer(OP_WR, phy_addr, ra, wd, rd);
    endtask
    // read and compare
    task automatic rdc(input logic [4:0] ra, input logic [15:0] exp);
        h.xfer(OP_RD, phy_addr, ra, 16'h0000, rd);
        check(rd, exp);
    endtask
    // two-cycle hardware reset, with or without power-on reset
    task automatic hw_reset(input logic p);
        @(negedge mclk);
        srst = 1'b1;
        por = p;
        cyc(2);
        srst = 1'b0;
        por = 1'b0;
        cyc(4);
    endtask
    task automatic results;
        $display("miscompares %0d tests_run %0d", miscompares, tests_run);
        if (miscompares == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // watchdog: the sequence needs about 20k cycles, this span is 40k cycles
    initial
    begin
        #200000;
        miscompares++;
        results();
    end
    initial
    begin
        cyc(2);
        srst = 1'b0;
        por = 1'b0;
        cyc(4);
        rdc(REG_CTRL2, CTRL2_RST);
        rdc(REG_CTRL3, CTRL3_RST);
        rdc(5'h15, 16'h0000);
        wr(REG_CTRL2, 16'h8301);
        check({hi_thresh_en, slow_osc_sel}, 2'b11);
        rdc(REG_CTRL2, 16'h8301);
        wr(REG_CTRL2, 16'h0000);
        check({hi_thresh_en, slow_osc_sel}, 2'b00);
        // foreign address: frame ignored, pin left to the pull-up
        h.xfer(OP_WR, phy_addr ^ 5'h01, REG_CTRL2, 16'hFFFF, rd);
        h.xfer(OP_RD, phy_addr ^ 5'h01, REG_CTRL2, 16'h0000, rd);
        check(rd, 16'hFFFF);
        // unknown opcode to our own address is ignored as well
        h.xfer(2'b11, phy_addr, REG_CTRL2, 16'hFFFF, rd);
        check(hi_thresh_en, 1'b0);
        // mode off forces detect true; active-low polarity shows that as a low level
        wr(REG_CTRL3, 16'h0005);
        check({energy_detect_out, rx_term_dis}, 2'b01);
        wr(REG_CTRL3, 16'h0049);
        check(energy_detect_out, 1'b0);
        // short and long loss delay, host method so no entry
        for (int l = 0; l < 2; l++)
        begin
            wr(REG_CTRL3, l ? 16'h004A : 16'h0048);
            check(energy_detect_out, 1'b1);
            cable_energy = 1'b0;
            cyc((l ? DLY_LONG_CYC : DLY_MIN_CYC) - 10);
            check(energy_detect_out, 1'b1);
            cyc(25);
            check({energy_detect_out, deep_sleep}, 2'b00);
            cable_energy = 1'b1;
            cyc(20);
        end
        wr(REG_CTRL3, 16'h0058);
        check(nv_copy_en, 1'b1);
        wr(REG_CTRL2, 16'hFFFF);
        check(deep_sleep, 1'b0);
        wr(REG_CTRL3, 16'h0078);
        check(deep_sleep, 1'b1);
        wr(REG_CTRL3, 16'h0058);
        check(deep_sleep, 1'b1);
        hw_reset(1'b0);
        check(deep_sleep, 1'b0);
        rdc(REG_CTRL3, 16'h0058);
        rdc(REG_CTRL2, 16'h0303);
        hw_reset(1'b1);
        rdc(REG_CTRL3, 16'h0000);
        wr(REG_CTRL3, 16'h0018);
        cable_energy = 1'b0;
        cyc(DLY_MIN_CYC - 10);
        check(deep_sleep, 1'b0);
        cyc(25);
        check(deep_sleep, 1'b1);
        wr(REG_CTRL3, 16'h0000);
        check(deep_sleep, 1'b1);
        cable_energy = 1'b1;
        hw_reset(1'b1);
        check(deep_sleep, 1'b0);
        results();
    end
endmodule
